// [design/pm_mailbox_pkg.sv]
// Purpose: Shared constants for the controller-side power-management byte mailbox.
// Assumes: Byte-wide controller register port with a 4-bit offset.
// Notes:   Offsets, field positions and the byte and flag-field reset values live here only.
package pm_mailbox_pkg;
  localparam int unsigned ADDR_W   = 4;
  localparam int unsigned DATA_W   = 8;
  localparam int unsigned FIFO_DEP = 16;

  // Controller-side register offsets
  localparam logic [3:0] OFF_STATUS   = 4'h0;
  localparam logic [3:0] OFF_OUT      = 4'h1;
  localparam logic [3:0] OFF_OUT_SCI  = 4'h2;
  localparam logic [3:0] OFF_OUT_SMI  = 4'h3;
  localparam logic [3:0] OFF_IN       = 4'h4;
  localparam logic [3:0] OFF_IN_SCI   = 4'h5;
  localparam logic [3:0] OFF_CONTROL  = 4'h6;

  // Status byte field positions
  localparam int unsigned ST_FLAGS_HI = 7;
  localparam int unsigned ST_FLAGS_LO = 4;
  localparam int unsigned ST_CMD      = 3;
  localparam int unsigned ST_SPARE    = 2;
  localparam int unsigned ST_IBF      = 1;
  localparam int unsigned ST_OBF      = 0;

  // Control byte field positions
  localparam int unsigned CT_AUTO     = 7;
  localparam int unsigned CT_OUTPUT_EMPTY_IRQ_ENABLE    = 1;
  localparam int unsigned CT_INPUT_FULL_IRQ_ENABLE    = 0;

  // Reset values and the control write mask
  localparam logic [7:0] RST_BYTE     = 8'h00;
  localparam logic [3:0] RST_FLAGS    = 4'h0;
  localparam logic [7:0] CTRL_WR_MASK = 8'h83;
endpackage

// [design/pm_channel_mailbox.sv]
// Purpose: Controller-side mailbox of one host power-management byte channel.
// Assumes: Host-side decode logic runs on core_clk and hands over strobes.
// Notes:   Host writes queue in a FIFO ahead of the single-byte input buffer.
`timescale 1ns/100ps

module pm_byte_fifo #(
  parameter int unsigned WIDTH = 9,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned PW = $clog2(DEPTH);

  // Pointers wrap naturally, so only powers of two are served
  generate
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("pm_byte_fifo DEPTH must be a power of two of at least 2");
    end
    if (WIDTH < 1) begin : g_bad_width
      $error("pm_byte_fifo WIDTH must be at least 1");
    end
  endgenerate

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [PW-1:0]    wr_ptr_r;
  logic [PW-1:0]    rd_ptr_r;
  logic [PW:0]      count_r;
  logic [PW:0]      count_nxt;
  logic             full_r;
  logic             push;
  logic             pop;

  assign push      = in_valid && !full_r;
  assign pop       = out_valid && out_ready;
  assign in_ready  = !full_r;
  assign out_valid = (count_r != '0);
  assign out_data  = mem_r[rd_ptr_r];

  // Occupancy; full is registered so the ready seen upstream is a flop
  always_comb begin
    count_nxt = count_r;
    if (push && !pop) begin
      count_nxt = count_r + 1'b1;
    end else if (pop && !push) begin
      count_nxt = count_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      count_r <= '0;
      full_r  <= 1'b0;
    end else begin
      count_r <= count_nxt;
      full_r  <= (count_nxt == (PW+1)'(DEPTH));
    end
  end

  // Pointers
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + 1'b1;
      end
    end
  end

  // Storage, one generate entry per word
  generate
    for (genvar i = 0; i < DEPTH; i++) begin : g_word
      always_ff @(posedge core_clk) begin
        if (!rst_n) begin
          mem_r[i] <= '0;
        end else if (push && wr_ptr_r == PW'(i)) begin
          mem_r[i] <= in_data;
        end
      end
    end
  endgenerate
endmodule

module pm_channel_mailbox #(
  parameter int unsigned FIFO_DEPTH = pm_mailbox_pkg::FIFO_DEP
) (
  input  wire logic                                core_clk,
  input  wire logic                                rst_n,
  // Controller register port
  input  wire logic [pm_mailbox_pkg::ADDR_W-1:0]   ec_addr,
  input  wire logic                                ec_wr,
  input  wire logic                                ec_rd,
  input  wire logic [pm_mailbox_pkg::DATA_W-1:0]   ec_wdata,
  output logic [pm_mailbox_pkg::DATA_W-1:0]        ec_rdata,
  // Host side strobes from the legacy port decode
  input  wire logic                                host_wr,
  input  wire logic                                host_wr_cmd,
  input  wire logic [pm_mailbox_pkg::DATA_W-1:0]   host_wdata,
  output logic                                     host_wr_ready,
  input  wire logic                                host_rd,
  output logic [pm_mailbox_pkg::DATA_W-1:0]        host_rdata,
  output logic [pm_mailbox_pkg::DATA_W-1:0]        host_status,
  // Interrupt generation enables and outputs
  input  wire logic                                sci_gen_en,
  input  wire logic                                smi_gen_en,
  output logic                                     sci_pulse,
  output logic                                     smi_pulse,
  output logic                                     ec_irq_pulse
);
  import pm_mailbox_pkg::*;

  localparam int unsigned FW = DATA_W + 1;

  logic [DATA_W-1:0] in_buf_r;
  logic [DATA_W-1:0] out_buf_r;
  logic [3:0]        flags_r;
  logic              cmd_r;
  logic              spare_r;
  logic              ibf_r;
  logic              obf_r;
  logic [7:0]        ctrl_r;
  logic [DATA_W-1:0] ec_rdata_r;
  logic              sci_r;
  logic              smi_r;
  logic              irq_r;
  logic [7:0]        status;
  logic [FW-1:0]     fifo_out;
  logic              fifo_valid;
  logic              fifo_in_ready;
  logic              load_in;
  logic              ec_in_rd;
  logic              ec_out_wr;
  logic              host_ob_rd;

  // Host writes queue here; the input buffer drains it one byte at a time
  pm_byte_fifo #(
    .WIDTH (FW),
    .DEPTH (FIFO_DEPTH)
  ) u_host_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_data   ({host_wr_cmd, host_wdata}),
    .in_valid  (host_wr),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out),
    .out_valid (fifo_valid),
    .out_ready (load_in)
  );

  // Decoded strobes
  assign ec_in_rd   = ec_rd && (ec_addr == OFF_IN || ec_addr == OFF_IN_SCI);
  assign ec_out_wr  = ec_wr && (ec_addr == OFF_OUT || ec_addr == OFF_OUT_SCI
                                || ec_addr == OFF_OUT_SMI);
  assign host_ob_rd = host_rd && obf_r;
  // A new byte only enters once the controller has taken the last one
  assign load_in    = fifo_valid && !ibf_r;

  // One status byte seen by both parties
  assign status = {flags_r, cmd_r, spare_r, ibf_r, obf_r};

  // Input buffer and command marker follow the byte that reaches it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      in_buf_r <= RST_BYTE;
      cmd_r    <= 1'b0;
    end else if (load_in) begin
      in_buf_r <= fifo_out[DATA_W-1:0];
      cmd_r    <= fifo_out[DATA_W];
    end
  end

  // Input full: load only happens while clear; a load wins over an input read in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ibf_r <= 1'b0;
    end else if (load_in) begin
      ibf_r <= 1'b1;
    end else if (ec_in_rd) begin
      ibf_r <= 1'b0;
    end
  end

  // Output buffer; any of the three output ports loads it
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_buf_r <= RST_BYTE;
    end else if (ec_out_wr) begin
      out_buf_r <= ec_wdata;
    end
  end

  // Output full: a controller write wins over a host read in the same cycle
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      obf_r <= 1'b0;
    end else if (ec_out_wr) begin
      obf_r <= 1'b1;
    end else if (host_ob_rd) begin
      obf_r <= 1'b0;
    end
  end

  // Software-owned status bits
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      flags_r <= RST_FLAGS;
      spare_r <= 1'b0;
    end else if (ec_wr && ec_addr == OFF_STATUS) begin
      flags_r <= ec_wdata[ST_FLAGS_HI:ST_FLAGS_LO];
      spare_r <= ec_wdata[ST_SPARE];
    end
  end

  // Control byte; unused bits stay zero
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl_r <= RST_BYTE;
    end else if (ec_wr && ec_addr == OFF_CONTROL) begin
      ctrl_r <= ec_wdata & CTRL_WR_MASK;
    end
  end

  // Read data returns one cycle after the read strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ec_rdata_r <= RST_BYTE;
    end else if (ec_rd) begin
      unique case (ec_addr)
        OFF_STATUS:  ec_rdata_r <= status;
        OFF_IN:      ec_rdata_r <= in_buf_r;
        OFF_IN_SCI:  ec_rdata_r <= in_buf_r;
        OFF_CONTROL: ec_rdata_r <= ctrl_r;
        default:     ec_rdata_r <= RST_BYTE; // Write-only or unmapped
      endcase
    end
  end

  // Host-facing SCI and SMI, one-cycle pulses
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sci_r <= 1'b0;
      smi_r <= 1'b0;
    end else begin
      sci_r <= sci_gen_en && ((ec_wr && ec_addr == OFF_OUT_SCI)
                              || (ec_rd && ec_addr == OFF_IN_SCI));
      smi_r <= smi_gen_en && ec_wr && ec_addr == OFF_OUT_SMI;
    end
  end

  // Controller interrupt, gated by auto mode so legacy polling stays quiet
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= ctrl_r[CT_AUTO]
               && ((ctrl_r[CT_INPUT_FULL_IRQ_ENABLE] && load_in)
                   || (ctrl_r[CT_OUTPUT_EMPTY_IRQ_ENABLE] && host_ob_rd && !ec_out_wr));
    end
  end

  // Host-visible copies, registered so every output is a flop
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      host_wr_ready <= 1'b0;
      host_status   <= RST_BYTE;
    end else begin
      host_wr_ready <= fifo_in_ready;
      host_status   <= status;
    end
  end

  assign host_rdata   = out_buf_r;
  assign ec_rdata     = ec_rdata_r;
  assign sci_pulse    = sci_r;
  assign smi_pulse    = smi_r;
  assign ec_irq_pulse = irq_r;
endmodule

// [tb/pm_channel_mailbox_chk.sv]
// Purpose: Port-level checks on the controller-side mailbox.
// Assumes: One clock, synchronous active-low reset.
// Notes:   SCI and SMI pulses are traced back to the access one cycle earlier.
`timescale 1ns/100ps
module pm_channel_mailbox_chk
  import pm_mailbox_pkg::*;
#(
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic              core_clk,
  input wire logic              rst_n,
  input wire logic [ADDR_W-1:0] ec_addr,
  input wire logic              ec_wr,
  input wire logic              ec_rd,
  input wire logic [DATA_W-1:0] ec_wdata,
  input wire logic [DATA_W-1:0] ec_rdata,
  input wire logic              host_rd,
  input wire logic [DATA_W-1:0] host_rdata,
  input wire logic [DATA_W-1:0] host_status,
  input wire logic              sci_gen_en,
  input wire logic              smi_gen_en,
  input wire logic              sci_pulse,
  input wire logic              smi_pulse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  // Host status copy lags one cycle, so flag checks wait an extra edge
  a_out_loads_byte: assert property (
    ec_wr && ec_addr inside {[OFF_OUT:OFF_OUT_SMI]} |=>
      host_rdata == $past(ec_wdata) ##1 host_status[ST_OBF]) else $error("output byte lost");
  a_obf_host_clear: assert property (
    host_rd && !ec_wr |=> ##1 !host_status[ST_OBF]) else $error("output full stuck");
  a_sci_has_cause: assert property (
    sci_pulse |-> $past(sci_gen_en && ((ec_wr && ec_addr == OFF_OUT_SCI) ||
      (ec_rd && ec_addr == OFF_IN_SCI)))) else $error("sci without cause");
  a_smi_has_cause: assert property (
    smi_pulse |-> $past(smi_gen_en && ec_wr && ec_addr == OFF_OUT_SMI)) else $error("stray smi");
  a_sci_on_out: assert property (
    ec_wr && ec_addr == OFF_OUT_SCI && sci_gen_en |=> sci_pulse) else $error("no sci on out");
  a_sci_on_in: assert property (
    ec_rd && ec_addr == OFF_IN_SCI && sci_gen_en |=> sci_pulse) else $error("no sci on in");
  a_status_shared: assert property (
    ec_rd && ec_addr == OFF_STATUS |=> ec_rdata == host_status) else $error("status differs");
  a_reset_clears: assert property (disable iff (1'b0)
    !rst_n ##1 !rst_n |-> host_status == RST_BYTE && host_rdata == RST_BYTE)
    else $error("reset value");
endmodule

// [tb/pm_host_model.sv]
// Purpose: Behavioural host on the legacy data and command ports.
// Assumes: Tasks are entered 1 ns after a rising clock edge.
// Notes:   Write data is inverted once released so no stale byte lingers.
`timescale 1ns/100ps
module pm_host_model (
  input  wire logic       core_clk,
  input  wire logic       host_wr_ready,
  input  wire logic [7:0] host_rdata,
  output logic            host_wr = 1'b0,
  output logic            host_wr_cmd = 1'b0,
  output logic [7:0]      host_wdata = 8'h00,
  output logic            host_rd = 1'b0
);
  // Command bytes go out with the port select high, data bytes low
  task automatic write_byte(input logic cmd, input logic [7:0] v);
    for (int n = 0; n < 50 && host_wr_ready !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    host_wr     = 1'b1;
    host_wr_cmd = cmd;
    host_wdata  = v;
    @(posedge core_clk);
    #1;
    host_wr    = 1'b0;
    host_wdata = ~v;
    // Let an edge pass so a following write never retoggles the strobe at once
    @(posedge core_clk);
    #1;
  endtask

  // The data port read returns the output byte
  task automatic read_byte(output logic [7:0] v);
    host_rd = 1'b1;
    @(posedge core_clk);
    v = host_rdata;
    #1;
    host_rd = 1'b0;
  endtask
endmodule

// [tb/tb_pm_channel_mailbox.sv]
// Purpose: Self-checking bench for the controller-side mailbox.
// Assumes: Inputs change 1 ns after the rising clock edge.
// Notes:   Host traffic comes from the host model tasks.
`timescale 1ns/100ps
module tb_pm_channel_mailbox;
  import pm_mailbox_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst_n = 1'b0;
  logic [3:0] ec_addr = 4'h0;
  logic       ec_wr = 1'b0;
  logic       ec_rd = 1'b0;
  logic [7:0] ec_wdata = 8'h00;
  logic       sci_gen_en = 1'b1;
  logic       smi_gen_en = 1'b1;
  logic [7:0] ec_rdata, host_wdata, host_rdata, host_status, d;
  logic       host_wr, host_wr_cmd, host_wr_ready, host_rd;
  logic       sci_pulse, smi_pulse, ec_irq_pulse, sci_seen, smi_seen;
  int         miscompares = 0;
  int         n_tests = 0;
  int         cycles = 0;
  int         irq_cnt = 0;

  always #2 core_clk = ~core_clk;

  pm_channel_mailbox #(.FIFO_DEPTH(16)) i_pm_channel_mailbox (
    .core_clk, .rst_n, .ec_addr, .ec_wr, .ec_rd, .ec_wdata, .ec_rdata, .host_wr, .host_wr_cmd,
    .host_wdata, .host_wr_ready, .host_rd, .host_rdata, .host_status, .sci_gen_en, .smi_gen_en,
    .sci_pulse, .smi_pulse, .ec_irq_pulse);
  pm_host_model i_pm_host_model (
    .core_clk, .host_wr_ready, .host_rdata, .host_wr, .host_wr_cmd, .host_wdata, .host_rd);

  // Hang guard and controller interrupt tally
  always @(posedge core_clk) begin
    cycles++;
    if (ec_irq_pulse === 1'b1) irq_cnt++;
    if (cycles == 6000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic tick();
    @(posedge core_clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", what, exp, got);
      miscompares++;
    end
  endtask

  // One register access; an idle edge follows so strobes never retoggle at once
  task automatic ec_op(input logic wr, input logic [3:0] a, input logic [7:0] v);
    ec_addr  = a;
    ec_wdata = v;
    ec_wr    = wr;
    ec_rd    = !wr;
    tick();
    ec_wr    = 1'b0;
    ec_rd    = 1'b0;
    d        = ec_rdata;
    sci_seen = sci_pulse;
    smi_seen = smi_pulse;
    tick();
  endtask

  task automatic wait_ibf();
    for (int n = 0; n < 20 && host_status[ST_IBF] !== 1'b1; n++) tick();
  endtask

  task automatic test_in();
    i_pm_host_model.write_byte(1'b1, 8'hA5);
    wait_ibf();
    ec_op(1'b0, OFF_STATUS, 8'h00);
    chk("cmd and full", 8'h0A, d);
    ec_op(1'b0, OFF_IN, 8'h00);
    chk("input byte", 8'hA5, d);
    ec_op(1'b0, OFF_STATUS, 8'h00);
    chk("full cleared", 8'h08, d);
    i_pm_host_model.write_byte(1'b0, 8'h3C);
    wait_ibf();
    ec_op(1'b0, OFF_IN_SCI, 8'h00);
    chk("input byte sci", 8'h3C, d);
    chk("sci on read", 8'h01, 8'(sci_seen));
    ec_op(1'b0, OFF_STATUS, 8'h00);
    chk("data flag", 8'h00, d);
    $display("input test done");
  endtask

  task automatic test_out();
    for (int a = 1; a <= 3; a++) begin
      ec_op(1'b1, 4'(a), 8'(8'h50 + a));
      chk("host byte", 8'(8'h50 + a), host_rdata);
      chk("sci", 8'(a == 2), 8'(sci_seen));
      chk("smi", 8'(a == 3), 8'(smi_seen));
      chk("obf set", 8'h01, host_status & 8'h01);
      i_pm_host_model.read_byte(d);
      chk("host read", 8'(8'h50 + a), d);
      tick();
      chk("obf clear", 8'h00, host_status & 8'h01);
    end
    // With generation disabled the port writes and reads must stay silent
    sci_gen_en = 1'b0;
    smi_gen_en = 1'b0;
    ec_op(1'b1, OFF_OUT_SCI, 8'h62);
    chk("sci masked", 8'h00, 8'(sci_seen));
    ec_op(1'b1, OFF_OUT_SMI, 8'h63);
    chk("smi masked", 8'h00, 8'(smi_seen));
    ec_op(1'b0, OFF_IN_SCI, 8'h00);
    chk("sci masked on read", 8'h00, 8'(sci_seen));
    i_pm_host_model.read_byte(d);
    chk("host read last", 8'h63, d);
    sci_gen_en = 1'b1;
    smi_gen_en = 1'b1;
    $display("output test done");
  endtask

  task automatic test_flags();
    ec_op(1'b1, OFF_STATUS, 8'hFF);
    ec_op(1'b0, OFF_STATUS, 8'h00);
    chk("flags", 8'hF4, d);
    chk("host view", 8'hF4, host_status);
    ec_op(1'b1, OFF_STATUS, 8'h00);
    ec_op(1'b0, OFF_STATUS, 8'h00);
    chk("flags cleared", 8'h00, d);
    ec_op(1'b0, 4'h9, 8'h00);
    chk("unmapped", 8'h00, d);
    $display("flag test done");
  endtask

  task automatic test_auto();
    int n0;
    ec_op(1'b1, OFF_CONTROL, 8'hFF);
    ec_op(1'b0, OFF_CONTROL, 8'h00);
    chk("control", 8'h83, d);
    n0 = irq_cnt;
    i_pm_host_model.write_byte(1'b0, 8'h77);
    wait_ibf();
    ec_op(1'b0, OFF_IN, 8'h00);
    chk("irq on full", 8'(n0 + 1), 8'(irq_cnt));
    ec_op(1'b1, OFF_OUT, 8'h11);
    i_pm_host_model.read_byte(d);
    tick();
    chk("irq on empty", 8'(n0 + 2), 8'(irq_cnt));
    ec_op(1'b1, OFF_CONTROL, 8'h03);
    i_pm_host_model.write_byte(1'b0, 8'h78);
    wait_ibf();
    ec_op(1'b0, OFF_IN, 8'h00);
    chk("irq gated", 8'(n0 + 2), 8'(irq_cnt));
    $display("auto test done");
  endtask

  // Fills the host queue until refused while the controller stalls
  task automatic test_fifo();
    for (int i = 0; i <= 16; i++) i_pm_host_model.write_byte(1'b0, 8'(i));
    tick();
    tick();
    chk("queue refuses", 8'h00, 8'(host_wr_ready));
    for (int i = 0; i <= 16; i++) begin
      wait_ibf();
      ec_op(1'b0, OFF_IN, 8'h00);
      chk("queued byte", 8'(i), d);
    end
    chk("queue drained", 8'h01, 8'(host_wr_ready));
    $display("fifo test done");
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    tick();
    ec_op(1'b0, OFF_STATUS, 8'h00);
    chk("reset status", 8'h00, d);
    chk("reset output", 8'h00, host_rdata);
    ec_op(1'b0, OFF_IN, 8'h00);
    chk("reset input", 8'h00, d);
    test_in();
    test_out();
    test_flags();
    test_auto();
    test_fifo();
    print_verdict();
  end
endmodule

bind pm_channel_mailbox pm_channel_mailbox_chk #(.FIFO_DEPTH(FIFO_DEPTH)) i_pm_channel_mailbox_chk (
  .core_clk, .rst_n, .ec_addr, .ec_wr, .ec_rd, .ec_wdata, .ec_rdata, .host_rd, .host_rdata,
  .host_status, .sci_gen_en, .smi_gen_en, .sci_pulse, .smi_pulse);
